// file: hw/sphc_ms_timer.sv
// Millisecond tick counter with a clear-on-idle run input
`timescale 1ns/1ps
module sphc_ms_timer (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // Control
    input wire logic i_tick,
    input wire logic i_run,
    input wire logic [sphc_pkg::TMR_W-1:0] i_limit,
    // Result
    output logic o_done
);
    import sphc_pkg::*;

    logic [TMR_W-1:0] count_q;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count_q <= '0;
        end else if (!i_run) begin
            count_q <= '0;
        end else if (i_tick && count_q < i_limit) begin
            count_q <= count_q + TMR_W'(1);
        end
    end

    assign o_done = i_run && (count_q >= i_limit);

endmodule

// file: hw/sphc_slot_ctrl.sv
// Power sequencing, fault latching and power-good for one hot-plug slot
`timescale 1ns/1ps
module sphc_slot_ctrl #(
    parameter int unsigned P_TICK_CYCLES = sphc_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // Register port
    input wire logic [sphc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [sphc_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [sphc_pkg::DATA_W-1:0] o_rd_data,
    output logic o_irq,
    // Controller and connector inputs
    input wire logic i_force_all_on_n,
    input wire logic i_card_present_n,
    input wire logic i_main_power_enable,
    input wire logic i_aux_power_enable,
    // Analog monitors
    input wire logic i_supply_ok,
    input wire logic i_main_overcurrent,
    input wire logic i_aux_overcurrent,
    input wire logic i_overtemp,
    input wire logic i_outputs_settled,
    // Switch commands
    output logic o_main_on,
    output logic o_aux_on,
    // Open-drain status pins
    output logic o_fault_latched_n_o,
    output logic o_fault_latched_n_oe_n,
    output logic o_power_good_n_o,
    output logic o_power_good_n_oe_n
);
    import sphc_pkg::*;

    logic [TICK_W-1:0] tick_cnt_q;
    logic tick, force_active, forced_q, present_q, debounce_done, card_removed;
    logic [CTRL_W-1:0] ctrl_q;
    logic [MS_W-1:0] oc_timeout_q, por_delay_q;
    logic [EVT_W-1:0] event_q, mask_q, event_set, event_clr;
    logic [DATA_W-1:0] rd_data_q;
    logic [STATE_W-1:0] state_word;
    sphc_state_t state_q;
    logic main_on_q, aux_on_q, main_oc_done, aux_oc_done, main_trip, aux_trip, fault_event;
    logic main_fault_q, aux_fault_q, main_en_prev_q, aux_en_prev_q, main_fall, aux_fall;
    logic main_tog_q, aux_tog_q, latch_clear, restart_done, pg_run, por_done, pg_d, pg_q, autorestart, por_skip;
    assign autorestart = ctrl_q[CTRL_AUTORESTART_BIT];
    assign por_skip = ctrl_q[CTRL_POR_SKIP_BIT];
    // Millisecond tick; all long delays count ticks so the counters stay narrow
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + TICK_W'(1);
        end
    end
    assign tick = (tick_cnt_q == TICK_W'(P_TICK_CYCLES - 1));

    // Software registers
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_q <= CTRL_RST;
            oc_timeout_q <= OC_TIMEOUT_MS_RST;
            por_delay_q <= POR_DELAY_MS_RST;
            mask_q <= EVT_RST;
        end else if (i_wr) begin
            unique case (i_addr)
                ADDR_CTRL: begin
                    ctrl_q <= i_wr_data[CTRL_W-1:0];
                end
                ADDR_OC_TIMEOUT: begin
                    oc_timeout_q <= i_wr_data[MS_W-1:0];
                end
                ADDR_POR_DELAY: begin
                    por_delay_q <= i_wr_data[MS_W-1:0];
                end
                ADDR_MASK: begin
                    mask_q <= i_wr_data[EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Sticky events; a new event wins over a write-one-to-clear
    assign event_clr = (i_wr && i_addr == ADDR_EVENT) ? i_wr_data[EVT_W-1:0] : EVT_RST;

    always_comb begin
        event_set = EVT_RST;
        event_set[EVT_FAULT_BIT] = fault_event;
        event_set[EVT_INSERT_BIT] = debounce_done && !present_q;
        event_set[EVT_REMOVE_BIT] = card_removed;
        event_set[EVT_PGOOD_BIT] = pg_d && !pg_q;
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            event_q <= EVT_RST;
        end else begin
            event_q <= (event_q & ~event_clr) | event_set;
        end
    end

    assign o_irq = |(event_q & mask_q);
    // Read data stand only in the cycle after the strobe
    assign state_word = {forced_q, aux_fault_q, main_fault_q, pg_q,
                         (state_q != ST_RUN), present_q, aux_on_q, main_on_q};

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_data_q <= '0;
        end else if (i_rd) begin
            unique case (i_addr)
                ADDR_CTRL: rd_data_q <= DATA_W'(ctrl_q);
                ADDR_OC_TIMEOUT: rd_data_q <= DATA_W'(oc_timeout_q);
                ADDR_POR_DELAY: rd_data_q <= DATA_W'(por_delay_q);
                ADDR_STATE: rd_data_q <= DATA_W'(state_word);
                ADDR_EVENT: rd_data_q <= DATA_W'(event_q);
                ADDR_MASK: rd_data_q <= DATA_W'(mask_q);
                default: rd_data_q <= '0;
            endcase
        end else begin
            rd_data_q <= '0;
        end
    end
    assign o_rd_data = rd_data_q;
    // Present-detect: slow to accept, instant to drop
    sphc_ms_timer u_debounce (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_tick(tick),
        .i_run(!i_card_present_n && !present_q),
        .i_limit(ms_to_ticks(DEBOUNCE_MS)),
        .o_done(debounce_done)
    );

    assign card_removed = present_q && i_card_present_n;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            present_q <= 1'b0;
        end else if (i_card_present_n) begin
            present_q <= 1'b0;
        end else if (debounce_done) begin
            present_q <= 1'b1;
        end
    end

    // Reset value matches an unconnected, pulled-up force pin
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            forced_q <= 1'b0;
        end else begin
            forced_q <= !i_force_all_on_n;
        end
    end

    assign force_active = !i_force_all_on_n && i_supply_ok;

    // Switch commands; faults still shut down a forced slot to protect it
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            main_on_q <= 1'b0;
            aux_on_q <= 1'b0;
        end else if (state_q != ST_RUN || fault_event) begin
            main_on_q <= 1'b0;
            aux_on_q <= 1'b0;
        end else if (force_active) begin
            main_on_q <= 1'b1;
            aux_on_q <= 1'b1;
        end else begin
            main_on_q <= i_supply_ok && present_q && !i_card_present_n && i_main_power_enable;
            aux_on_q <= i_supply_ok && present_q && !i_card_present_n && i_aux_power_enable;
        end
    end
    assign o_main_on = main_on_q;
    assign o_aux_on = aux_on_q;
    // Overcurrent qualification per rail
    sphc_ms_timer u_main_oc (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_tick(tick),
        .i_run(i_main_overcurrent && main_on_q),
        .i_limit(ms_to_ticks(oc_timeout_q)),
        .o_done(main_oc_done)
    );

    sphc_ms_timer u_aux_oc (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_tick(tick),
        .i_run(i_aux_overcurrent && aux_on_q),
        .i_limit(ms_to_ticks(oc_timeout_q)),
        .o_done(aux_oc_done)
    );

    assign main_trip = main_oc_done || i_overtemp;
    assign aux_trip = aux_oc_done;
    assign fault_event = (state_q == ST_RUN) && (main_trip || aux_trip);

    // Enable toggles seen since the fault, used by the latch-off release
    assign main_fall = main_en_prev_q && !i_main_power_enable;
    assign aux_fall = aux_en_prev_q && !i_aux_power_enable;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            main_en_prev_q <= 1'b0;
            aux_en_prev_q <= 1'b0;
        end else begin
            main_en_prev_q <= i_main_power_enable;
            aux_en_prev_q <= i_aux_power_enable;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            main_tog_q <= 1'b0;
            aux_tog_q <= 1'b0;
        end else if (state_q != ST_LATCHED) begin
            main_tog_q <= 1'b0;
            aux_tog_q <= 1'b0;
        end else begin
            main_tog_q <= main_tog_q || main_fall;
            aux_tog_q <= aux_tog_q || aux_fall;
        end
    end

    // An aux fault, alone or with a main fault, takes the stricter release
    assign latch_clear = aux_fault_q ?
        ((main_tog_q || main_fall) && (aux_tog_q || aux_fall)) :
        main_fall;

    sphc_ms_timer u_restart (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_tick(tick),
        .i_run(state_q == ST_RESTART),
        .i_limit(ms_to_ticks(RESTART_MS)),
        .o_done(restart_done)
    );

    // Fault state
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= ST_RUN;
        end else begin
            unique case (state_q)
                ST_RUN: begin
                    if (fault_event) begin
                        state_q <= autorestart ? ST_RESTART : ST_LATCHED;
                    end
                end
                ST_LATCHED: begin
                    if (latch_clear) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RESTART: begin
                    if (restart_done) begin
                        state_q <= ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // Which rail tripped; cleared when the slot leaves the fault state
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            main_fault_q <= 1'b0;
            aux_fault_q <= 1'b0;
        end else if (fault_event) begin
            main_fault_q <= main_trip;
            aux_fault_q <= aux_trip;
        end else if (state_q == ST_RUN) begin
            main_fault_q <= 1'b0;
            aux_fault_q <= 1'b0;
        end
    end

    assign o_fault_latched_n_o = 1'b0;
    assign o_fault_latched_n_oe_n = (state_q == ST_RUN);

    // Power-good after settling plus the POR delay
    assign pg_run = (main_on_q || aux_on_q) && i_outputs_settled && state_q == ST_RUN;

    sphc_ms_timer u_por (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_tick(tick),
        .i_run(pg_run && !por_skip),
        .i_limit(ms_to_ticks(por_delay_q)),
        .o_done(por_done)
    );

    assign pg_d = pg_run && !fault_event && (por_skip || por_done);

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pg_q <= 1'b0;
        end else begin
            pg_q <= pg_d;
        end
    end

    assign o_power_good_n_o = 1'b0;
    assign o_power_good_n_oe_n = !pg_q;

endmodule

// file: pkg/sphc_pkg.sv
// Shared constants, types and helpers for the slot power hot-plug controller
package sphc_pkg;

    // Clock and millisecond tick
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned NS_PER_MS = 1000000;
    localparam int unsigned TICK_CYCLES = NS_PER_MS / CLK_PERIOD_NS;
    localparam int TICK_W = $clog2(TICK_CYCLES);

    // Millisecond timers
    localparam int TMR_W = 9;
    localparam int MS_W = 8;
    localparam logic [MS_W-1:0] DEBOUNCE_MS = 8'h04;
    localparam logic [MS_W-1:0] OC_TIMEOUT_MS_RST = 8'h0B;
    localparam logic [MS_W-1:0] POR_DELAY_MS_RST = 8'hA0;
    localparam logic [MS_W-1:0] RESTART_MS = 8'h64;

    // Register bus
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_OC_TIMEOUT = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_POR_DELAY = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 5'h0C;
    localparam logic [ADDR_W-1:0] ADDR_EVENT = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 5'h14;

    // Control register fields
    localparam int CTRL_W = 2;
    localparam int CTRL_AUTORESTART_BIT = 0;
    localparam int CTRL_POR_SKIP_BIT = 1;
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;

    // Event register fields, mask has the same layout
    localparam int EVT_W = 4;
    localparam int EVT_FAULT_BIT = 0;
    localparam int EVT_INSERT_BIT = 1;
    localparam int EVT_REMOVE_BIT = 2;
    localparam int EVT_PGOOD_BIT = 3;
    localparam logic [EVT_W-1:0] EVT_RST = 4'h0;

    // State register: {forced, aux_fault, main_fault, pgood, fault, present, aux_on, main_on}
    localparam int STATE_W = 8;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_LATCHED = 3'b010,
        ST_RESTART = 3'b100
    } sphc_state_t;

    // One extra tick so a free-running tick never shortens a least time
    function automatic logic [TMR_W-1:0] ms_to_ticks(input logic [MS_W-1:0] ms);
        return TMR_W'(ms) + TMR_W'(1);
    endfunction

endpackage

// file: testbench/slot_power_hotplug_control_bench.sv
// Self-checking bench for the slot power controller
`timescale 1ns/1ps
module slot_power_hotplug_control_bench;
    import sphc_pkg::*;
    localparam int TICK = 10;
    logic clock, arst_n, wr, rd, irq, force_n, card_n, main_req, aux_req, clr_main, clr_aux;
    logic supply, moc, aoc, ot, settled, main_en, aux_en, main_on, aux_on, f_o, f_oe_n, pg_o, pg_oe_n;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, r;
    wire fault_n = f_oe_n ? 1'b1 : f_o;
    wire pg_n = pg_oe_n ? 1'b1 : pg_o;
    int n, checks, n_fail;
    integer seed;
    logic [4:0] reg_a [6] = '{5'h00, 5'h04, 5'h08, 5'h10, 5'h14, 5'h18};
    logic [31:0] reg_e [6] = '{32'h0, 32'hB, 32'hA0, 32'h0, 32'h0, 32'h0};
    sphc_slot_ctrl #(.P_TICK_CYCLES(TICK)) i_sphc_slot_ctrl (.i_clock(clock), .i_arst_n(arst_n),
        .i_addr(addr), .i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .o_irq(irq),
        .i_force_all_on_n(force_n), .i_card_present_n(card_n), .i_main_power_enable(main_en),
        .i_aux_power_enable(aux_en), .i_supply_ok(supply), .i_main_overcurrent(moc), .i_aux_overcurrent(aoc),
        .i_overtemp(ot), .i_outputs_settled(settled), .o_main_on(main_on), .o_aux_on(aux_on),
        .o_fault_latched_n_o(f_o), .o_fault_latched_n_oe_n(f_oe_n), .o_power_good_n_o(pg_o),
        .o_power_good_n_oe_n(pg_oe_n));
    sphc_host_model i_sphc_host_model (.i_clock(clock), .i_arst_n(arst_n), .i_main_req(main_req),
        .i_aux_req(aux_req), .i_clear_main(clr_main), .i_clear_aux(clr_aux), .i_fault_n(fault_n),
        .o_main_power_enable(main_en), .o_aux_power_enable(aux_en));
    always #5 clock = ~clock;
    function automatic int cyc(input int ms);
        return ms * TICK;
    endfunction
    function automatic logic in_rng(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction
    function automatic logic exp_on(input logic fn, input logic en);
        return !fn || en;
    endfunction
    task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", w, exp, seen);
        end
    endtask
    task automatic tk(input int k);
        repeat (k) begin
            @(posedge clock);
            n++;
        end
        #1;
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge clock) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clock) wr <= 1'b0;
    endtask
    task automatic rdc(input string w, input logic [4:0] a, input logic [31:0] e);
        @(posedge clock) {addr, rd} <= {a, 1'b1};
        @(posedge clock) rd <= 1'b0;
        #1 chk(w, rdata, e);
    endtask
    task automatic clr(input logic m);
        @(posedge clock) {clr_main, clr_aux} <= {m, !m};
        @(posedge clock) {clr_main, clr_aux} <= 2'b00;
        tk(6);
    endtask
    task automatic results;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Whole run is about 3200 cycles; about six times that means a hang
    initial begin
        #200000;
        n_fail++;
        results;
    end
    initial begin
        clock = 1'b0;
        {arst_n, addr, wdata, wr, rd} = '0;
        {force_n, card_n, main_req, aux_req, clr_main, clr_aux} = 6'b110000;
        {supply, moc, aoc, ot, settled} = 5'b10000;
        seed = 32'h59F2CB6B;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        foreach (reg_a[i]) rdc("reset value", reg_a[i], reg_e[i]);
        wr_reg(5'h18, 32'hFFFFFFFF);
        rdc("unmapped", 5'h18, 32'h0);
        wr_reg(ADDR_OC_TIMEOUT, 32'hFFFFFF5A);
        wr_reg(ADDR_POR_DELAY, 32'h0000013C);
        rdc("oc timeout field", ADDR_OC_TIMEOUT, 32'h5A);
        rdc("por delay field", ADDR_POR_DELAY, 32'h3C);
        wr_reg(ADDR_OC_TIMEOUT, 32'hB);
        wr_reg(ADDR_POR_DELAY, 32'hA0);
        wr_reg(ADDR_MASK, 32'hF);
        @(posedge clock) {card_n, main_req, aux_req} <= 3'b011;
        n = 0;
        tk(38);
        chk("main before debounce", main_on, 1'b0);
        while (main_on !== 1'b1 && n < 70) tk(1);
        chk("outputs after debounce", {main_on, aux_on}, 2'b11);
        rdc("insert event", ADDR_EVENT, 32'h2);
        chk("irq on insert", irq, 1'b1);
        wr_reg(ADDR_EVENT, 32'h2);
        tk(1);
        chk("irq cleared", irq, 1'b0);
        @(posedge clock) settled <= 1'b1;
        n = 0;
        while (pg_n !== 1'b0 && n < 1700) tk(1);
        chk("power good delay", in_rng(n, cyc(160), cyc(163)), 1'b1);
        rdc("state", ADDR_STATE, 32'h17);
        rdc("pg event", ADDR_EVENT, 32'h8);
        repeat (16) begin
            r = $random(seed);
            @(posedge clock) {force_n, main_req, aux_req} <= r[2:0];
            tk(2);
            chk("main follow", main_on, exp_on(r[2], r[1]));
            chk("aux follow", aux_on, exp_on(r[2], r[0]));
        end
        @(posedge clock) {force_n, main_req, aux_req} <= 3'b111;
        wr_reg(ADDR_MASK, 32'h0);
        @(posedge clock) ot <= 1'b1;
        @(posedge clock) ot <= 1'b0;
        tk(2);
        chk("overtemp fault", {fault_n, main_on, irq}, 3'b000);
        wr_reg(ADDR_MASK, 32'h1);
        tk(1);
        chk("irq unmasked", irq, 1'b1);
        wr_reg(ADDR_EVENT, 32'hF);
        tk(20);
        chk("latched stays", {fault_n, main_on, irq}, 3'b000);
        clr(1'b1);
        chk("main toggle clears", {fault_n, main_on}, 2'b11);
        @(posedge clock) aoc <= 1'b1;
        n = 0;
        while (fault_n !== 1'b0 && n < 200) tk(1);
        chk("overcurrent timeout", in_rng(n, cyc(11), cyc(13)), 1'b1);
        @(posedge clock) aoc <= 1'b0;
        clr(1'b1);
        chk("main toggle only", fault_n, 1'b0);
        clr(1'b0);
        chk("both toggled", {fault_n, aux_on}, 2'b11);
        @(posedge clock) moc <= 1'b1;
        n = 0;
        while (fault_n !== 1'b0 && n < 200) tk(1);
        chk("main overcurrent", in_rng(n, cyc(11), cyc(13)), 1'b1);
        @(posedge clock) moc <= 1'b0;
        clr(1'b1);
        chk("main oc toggle clears", {fault_n, main_on}, 2'b11);
        @(posedge clock) {supply, force_n, main_req, aux_req} <= 4'b0000;
        tk(2);
        chk("force without supply", main_on, 1'b0);
        @(posedge clock) supply <= 1'b1;
        tk(2);
        chk("force on", {main_on, aux_on}, 2'b11);
        @(posedge clock) {force_n, main_req, aux_req} <= 3'b111;
        wr_reg(ADDR_EVENT, 32'hF);
        @(posedge clock) card_n <= 1'b1;
        tk(1);
        chk("removal", {main_on, aux_on}, 2'b00);
        rdc("remove event", ADDR_EVENT, 32'h4);
        wr_reg(ADDR_CTRL, 32'h3);
        @(posedge clock) card_n <= 1'b0;
        n = 0;
        while (main_on !== 1'b1 && n < 70) tk(1);
        tk(2);
        chk("por skip", pg_n, 1'b0);
        @(posedge clock) ot <= 1'b1;
        @(posedge clock) ot <= 1'b0;
        n = 0;
        while (fault_n !== 1'b0 && n < 5) tk(1);
        while (fault_n !== 1'b1 && n < 1200) tk(1);
        chk("restart delay", in_rng(n, cyc(100), cyc(102)), 1'b1);
        tk(2);
        chk("restart on", main_on, 1'b1);
        results;
    end
endmodule

// file: testbench/sphc_host_model.sv
// Controller model driving the slot enables and fault clearing toggles
`timescale 1ns/1ps
module sphc_host_model (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // Bench requests and fault pin
    input wire logic i_main_req,
    input wire logic i_aux_req,
    input wire logic i_clear_main,
    input wire logic i_clear_aux,
    input wire logic i_fault_n,
    // Enables
    output logic o_main_power_enable,
    output logic o_aux_power_enable
);
    logic [1:0] drop_main_q;
    logic [1:0] drop_aux_q;
    // Toggle only while the pin reads a fault, so a healthy slot never blinks
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            drop_main_q <= 2'h0;
            drop_aux_q <= 2'h0;
        end else begin
            drop_main_q <= (i_clear_main && !i_fault_n) ? 2'h3 : drop_main_q >> 1;
            drop_aux_q <= (i_clear_aux && !i_fault_n) ? 2'h3 : drop_aux_q >> 1;
        end
    end
    assign o_main_power_enable = i_main_req && !drop_main_q[0];
    assign o_aux_power_enable = i_aux_req && !drop_aux_q[0];
endmodule

// file: testbench/sphc_slot_ctrl_props.sv
// Concurrent checks on the slot power controller ports
`timescale 1ns/1ps
module sphc_slot_ctrl_props #(
    parameter int unsigned P_TICK_CYCLES = 10
) (
    // Clock, reset and register port
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic [sphc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [sphc_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [sphc_pkg::DATA_W-1:0] o_rd_data,
    // Slot inputs
    input wire logic i_force_all_on_n,
    input wire logic i_card_present_n,
    input wire logic i_main_power_enable,
    input wire logic i_supply_ok,
    input wire logic i_main_overcurrent,
    input wire logic i_aux_overcurrent,
    input wire logic i_overtemp,
    input wire logic i_outputs_settled,
    // Slot outputs
    input wire logic o_main_on,
    input wire logic o_aux_on,
    input wire logic o_fault_latched_n_oe_n,
    input wire logic o_power_good_n_oe_n
);
    import sphc_pkg::*;
    logic [15:0] pres_q;
    logic [15:0] oc_q;
    logic [15:0] pg_q;
    logic skip_q;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    // Presence and power-good run lengths saturate so long idle spans never wrap; the overcurrent one does not
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pres_q <= 16'h0;
            oc_q <= 16'h0;
            pg_q <= 16'h0;
            skip_q <= 1'b0;
        end else begin
            pres_q <= i_card_present_n ? 16'h0 : pres_q + {15'h0, ~&pres_q};
            oc_q <= ((i_main_overcurrent && o_main_on) || (i_aux_overcurrent && o_aux_on)) ? oc_q + 16'h1 : 16'h0;
            pg_q <= ((o_main_on || o_aux_on) && i_outputs_settled && o_fault_latched_n_oe_n) ?
                pg_q + {15'h0, ~&pg_q} : 16'h0;
            if (i_wr && i_addr == ADDR_CTRL) begin
                skip_q <= i_wr_data[CTRL_POR_SKIP_BIT];
            end
        end
    end
    AST_REMOVE_OFF: assert property ($rose(i_card_present_n) && i_force_all_on_n |=> !o_main_on && !o_aux_on)
        else $error("outputs on after removal");
    AST_MAIN_OFF: assert property (i_force_all_on_n && !i_main_power_enable |=> !o_main_on)
        else $error("main on while disabled");
    AST_FORCE_ON: assert property (!i_force_all_on_n && i_supply_ok && o_fault_latched_n_oe_n && !i_overtemp &&
        !i_main_overcurrent && !i_aux_overcurrent |=> o_main_on && o_aux_on) else $error("force did not turn on");
    AST_OT_SHUTDOWN: assert property (i_overtemp && o_main_on |-> ##[1:2] (!o_fault_latched_n_oe_n && !o_main_on))
        else $error("no shutdown on overtemperature");
    AST_FAULT_OFF: assert property (!o_fault_latched_n_oe_n |-> !o_main_on && !o_aux_on)
        else $error("outputs on while fault latched");
    AST_OC_EARLY: assert property ($fell(o_fault_latched_n_oe_n) && !$past(i_overtemp) && !$past(i_overtemp, 2)
        |-> $past(oc_q) >= 11 * P_TICK_CYCLES - 2) else $error("overcurrent fault too early");
    AST_OC_BOUND: assert property (oc_q <= 13 * P_TICK_CYCLES + 4)
        else $error("overcurrent fault too late");
    AST_PG_EARLY: assert property ($fell(o_power_good_n_oe_n) |-> skip_q || pg_q >= 160 * P_TICK_CYCLES)
        else $error("power good too early");
    AST_PG_BOUND: assert property (pg_q > 162 * P_TICK_CYCLES + 4 |-> !o_power_good_n_oe_n)
        else $error("power good too late");
    AST_DEBOUNCE: assert property ($rose(o_main_on) && $past(i_force_all_on_n) |-> $past(pres_q) >= 4 * P_TICK_CYCLES - 2)
        else $error("outputs on before debounce");
    AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rd_data == 32'h0)
        else $error("read data outside read cycle");
    cover property ($fell(o_fault_latched_n_oe_n));
    cover property ($fell(o_power_good_n_oe_n));
    cover property ($rose(i_card_present_n) ##1 !o_main_on);
endmodule
bind sphc_slot_ctrl sphc_slot_ctrl_props #(.P_TICK_CYCLES(P_TICK_CYCLES)) i_sphc_slot_ctrl_props (.*);
